//--- hdl/lpw_wake_ctrl.sv
// wait and stop mode control, wake qualification and stop recovery
`timescale 1ns/100ps
`include "lpw_regs.svh"

module lpw_wake_ctrl
	import lpw_pkg::*;
#(
	parameter int KBD_N     = `LPW_KBD_PINS,
	parameter int CNT_W     = `LPW_REC_CNT_W,
	parameter int REC_LONG  = `LPW_REC_LONG,
	parameter int REC_SHORT = `LPW_REC_SHORT
)
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             wait_req,
	input  wire logic             stop_req,
	input  wire logic             crystal_ref_clock,
	input  wire logic             osc_run_in_stop,
	input  wire logic             short_recovery_select,
	input  wire logic             irq_wake_mask,
	input  wire logic             kbd_wake_mask,
	input  wire logic             irq_pin_n,
	input  wire logic [KBD_N-1:0] kbd_pin_n,
	input  wire logic             rst_pin_n,
	input  wire logic             wdt_timeout,
	input  wire logic             sdm_enable,
	input  wire logic             sdm_reset_enable,
	input  wire logic             sdm_trip,
	input  wire logic             break_irq,
	input  wire logic             pll_irq,
	input  wire logic [2:0]       timer_one_irq,
	input  wire logic [1:0]       timer_two_irq,
	input  wire logic [1:0]       spi_irq,
	input  wire logic [2:0]       ser_irq,
	input  wire logic             adc_irq,
	input  wire logic             pwt_rollover,
	output lpw_mode_t             mode,
	output logic                  cpu_clk_en,
	output logic                  bus_clk_en,
	output lpw_periph_t           periph,
	output logic                  spi_abort,
	output logic                  wake_pulse,
	output logic [15:0]           wake_vector,
	output logic                  wake_by_reset
);

	// refuse an empty keypad
	if (KBD_N < 1)
	begin : g_bad_kbd
		$error("lpw_wake_ctrl: at least one keypad pin is needed");
	end

	typedef struct packed
	{
		lpw_mode_t        mode;
		logic             xclk_prev;
		logic             irq_prev;
		logic [KBD_N-1:0] kbd_prev;
		logic             rec_start;
		logic             cpu_clk_en;
		logic             bus_clk_en;
		lpw_periph_t      periph;
		logic             spi_abort;
		logic             wake_pulse;
		logic [15:0]      wake_vector;
		logic             wake_by_reset;
	} lpw_state_t;

	lpw_state_t  st;
	lpw_state_t  next_st;
	lpw_src_t    src;
	logic        in_wait;
	logic        in_stop;
	logic        xclk_edge;
	logic        irq_fall;
	logic        kbd_fall;
	logic        reset_req;
	logic [15:0] sel_vector;
	logic        sel_any;
	logic        sel_reset;
	logic        rec_busy;
	logic        rec_done;

	////////////////////////////////////////////////////////////////////////
	// edge detection on synchronous pins
	assign in_wait   = (st.mode == LPW_WAIT);
	assign in_stop   = (st.mode == LPW_STOP) || (st.mode == LPW_RECOVER);
	assign xclk_edge = crystal_ref_clock && !st.xclk_prev;
	assign irq_fall  = st.irq_prev && !irq_pin_n;
	assign kbd_fall  = |(st.kbd_prev & ~kbd_pin_n);

	////////////////////////////////////////////////////////////////////////
	// reset sources; watchdog clock stops in stop mode
	assign reset_req = !rst_pin_n
		|| (sdm_enable && sdm_reset_enable && sdm_trip)
		|| (wdt_timeout && in_wait);

	////////////////////////////////////////////////////////////////////////
	// qualify requests for the current mode
	always_comb
	begin
		src         = '0;
		src.reset   = reset_req;
		src.brk     = break_irq;
		src.irq     = irq_fall && !irq_wake_mask;
		src.kbd     = kbd_fall && !kbd_wake_mask;
		src.pwt     = pwt_rollover && (in_wait || (in_stop && osc_run_in_stop));
		src.pll     = pll_irq && in_wait;
		src.t1_ovf  = timer_one_irq[0] && in_wait;
		src.t1_ch1  = timer_one_irq[1] && in_wait;
		src.t1_ch0  = timer_one_irq[2] && in_wait;
		src.t2_ovf  = timer_two_irq[0] && in_wait;
		src.t2_ch0  = timer_two_irq[1] && in_wait;
		src.spi_tx  = spi_irq[0] && in_wait;
		src.spi_rx  = spi_irq[1] && in_wait;
		src.ser_tx  = ser_irq[0] && in_wait;
		src.ser_rx  = ser_irq[1] && in_wait;
		src.ser_err = ser_irq[2] && in_wait;
		src.adc     = adc_irq && in_wait;
	end

	lpw_vector_sel u_vector_sel
	(
		.src      (src),
		.vector   (sel_vector),
		.any      (sel_any),
		.is_reset (sel_reset)
	);

	lpw_recovery_counter #(
		.CNT_W     (CNT_W),
		.REC_LONG  (REC_LONG),
		.REC_SHORT (REC_SHORT)
	) u_recovery
	(
		.clk       (clk),
		.resetn    (resetn),
		.start     (st.rec_start),
		.short_sel (short_recovery_select),
		.xclk_edge (xclk_edge),
		.busy      (rec_busy),
		.done      (rec_done)
	);

	////////////////////////////////////////////////////////////////////////
	// mode sequencing and output levels
	always_comb
	begin
		next_st            = st;
		next_st.xclk_prev  = crystal_ref_clock;
		next_st.irq_prev   = irq_pin_n;
		next_st.kbd_prev   = kbd_pin_n;
		next_st.rec_start  = 1'b0;
		next_st.spi_abort  = 1'b0;
		next_st.wake_pulse = 1'b0;
		case (st.mode)
			LPW_RUN:
			begin
				if (stop_req)
					next_st.mode = LPW_STOP;
				else if (wait_req)
					next_st.mode = LPW_WAIT;
			end
			LPW_WAIT:
			begin
				// bus clock still runs, so restart at once
				if (sel_any)
				begin
					next_st.mode          = LPW_RUN;
					next_st.wake_pulse    = 1'b1;
					next_st.wake_vector   = sel_vector;
					next_st.wake_by_reset = sel_reset;
				end
			end
			LPW_STOP:
			begin
				// any wake from stop goes through recovery
				if (sel_any)
				begin
					next_st.mode          = LPW_RECOVER;
					next_st.rec_start     = 1'b1;
					next_st.wake_vector   = sel_vector;
					next_st.wake_by_reset = sel_reset;
					next_st.spi_abort     = sel_reset;
				end
			end
			LPW_RECOVER:
			begin
				// a late reset still overrides an interrupt wake
				if (src.reset && !st.wake_by_reset)
				begin
					next_st.wake_vector   = `LPW_VEC_RESET;
					next_st.wake_by_reset = 1'b1;
					next_st.spi_abort     = 1'b1;
				end
				if (rec_done)
				begin
					next_st.mode       = LPW_RUN;
					next_st.wake_pulse = 1'b1;
				end
			end
			default:
			begin
				next_st.mode = LPW_RUN;
			end
		endcase

		// levels follow the mode being entered
		next_st.cpu_clk_en        = (next_st.mode == LPW_RUN);
		next_st.bus_clk_en        = (next_st.mode == LPW_RUN) || (next_st.mode == LPW_WAIT);
		next_st.periph.ser_run    = (next_st.mode == LPW_RUN) || (next_st.mode == LPW_WAIT);
		next_st.periph.spi_run    = (next_st.mode == LPW_RUN) || (next_st.mode == LPW_WAIT);
		next_st.periph.tim_run    = (next_st.mode == LPW_RUN) || (next_st.mode == LPW_WAIT);
		next_st.periph.pwt_run    = (next_st.mode == LPW_STOP) ? osc_run_in_stop
			: (next_st.mode != LPW_RECOVER);
		next_st.periph.pwt_access = (next_st.mode == LPW_RUN);
		next_st.periph.sdm_active = sdm_enable;
		next_st.periph.irq_active = 1'b1;
		next_st.periph.kbd_active = 1'b1;
		next_st.periph.osc_run    = (next_st.mode != LPW_STOP) || osc_run_in_stop;
	end

	////////////////////////////////////////////////////////////////////////
	// state register; pins idle high at reset
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st                   <= '0;
			st.mode              <= LPW_RUN;
			st.irq_prev          <= 1'b1;
			st.kbd_prev          <= '1;
			st.cpu_clk_en        <= 1'b1;
			st.bus_clk_en        <= 1'b1;
			st.periph.ser_run    <= 1'b1;
			st.periph.spi_run    <= 1'b1;
			st.periph.tim_run    <= 1'b1;
			st.periph.pwt_run    <= 1'b1;
			st.periph.pwt_access <= 1'b1;
			st.periph.irq_active <= 1'b1;
			st.periph.kbd_active <= 1'b1;
			st.periph.osc_run    <= 1'b1;
			st.wake_vector       <= `LPW_VEC_RESET;
			st.wake_by_reset     <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign mode          = st.mode;
	assign cpu_clk_en    = st.cpu_clk_en;
	assign bus_clk_en    = st.bus_clk_en;
	assign periph        = st.periph;
	assign spi_abort     = st.spi_abort;
	assign wake_pulse    = st.wake_pulse;
	assign wake_vector   = st.wake_vector;
	assign wake_by_reset = st.wake_by_reset;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_IRQ_MASKED:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP && irq_fall && irq_wake_mask && !kbd_fall && rst_pin_n && !sdm_trip
			&& !break_irq && !pwt_rollover) |=> st.mode == LPW_STOP)
	else $error("masked irq edge left stop mode");

	AST_WAIT_RUNS:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_WAIT) |-> periph.ser_run && periph.spi_run && periph.tim_run && bus_clk_en && !cpu_clk_en)
	else $error("peripherals not running in wait");

	AST_STOP_HALTS:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP) |-> !periph.ser_run && !periph.spi_run && !periph.tim_run)
	else $error("peripheral still running in stop");

	AST_SPI_ABORT:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP && src.reset) |=> spi_abort && st.mode == LPW_RECOVER ##1 !spi_abort)
	else $error("reset wake did not abort spi once");

	AST_PWT_NOACCESS:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode != LPW_RUN) |-> !periph.pwt_access)
	else $error("wake timer accessible in low power mode");

	AST_PWT_STOP:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP) |-> periph.pwt_run == $past(osc_run_in_stop))
	else $error("wake timer run level wrong in stop");

	AST_PWT_VEC:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP && src == lpw_src_t'(17'h00001)) |=> wake_vector == `LPW_VEC_PWT && !wake_by_reset)
	else $error("wake timer rollover vector wrong");

	AST_RESET_VEC:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_WAIT && src.reset) |=> st.mode == LPW_RUN && wake_pulse && wake_by_reset
			&& wake_vector == `LPW_VEC_RESET)
	else $error("reset wake from wait not vectored to reset");

	AST_IRQ_VEC:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_WAIT && src.irq && !src.reset && !src.brk) |=> wake_pulse
			&& wake_vector == `LPW_VEC_IRQ)
	else $error("irq wake vector wrong");

	AST_REC_HOLD:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_STOP && sel_any) |=> !bus_clk_en [*8])
	else $error("clocks restarted early after stop exit");

	AST_REC_EXIT:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_RECOVER && rec_done) |=> st.mode == LPW_RUN && wake_pulse && bus_clk_en && cpu_clk_en)
	else $error("recovery end did not restart clocks");

	AST_REC_BUSY:
	assert property (@(posedge clk) disable iff (!resetn)
		(st.mode == LPW_RECOVER && !st.rec_start && !rec_done) |-> rec_busy)
	else $error("recovery counter idle while clocks held");

endmodule : lpw_wake_ctrl

//--- hdl/lpw_regs.svh
// vector addresses, recovery counts and widths for the wake control block
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH

// vector locations fetched after wake-up
`define LPW_VEC_RESET   16'hfffe
`define LPW_VEC_BRK     16'hfffc
`define LPW_VEC_IRQ     16'hfffa
`define LPW_VEC_PLL     16'hfff8
`define LPW_VEC_T1_CH0  16'hfff6
`define LPW_VEC_T1_CH1  16'hfff4
`define LPW_VEC_T1_OVF  16'hfff2
`define LPW_VEC_T2_CH0  16'hfff0
`define LPW_VEC_T2_OVF  16'hffec
`define LPW_VEC_SPI_RX  16'hffea
`define LPW_VEC_SPI_TX  16'hffe8
`define LPW_VEC_SER_ERR 16'hffe6
`define LPW_VEC_SER_RX  16'hffe4
`define LPW_VEC_SER_TX  16'hffe2
`define LPW_VEC_KBD     16'hffde
`define LPW_VEC_ADC     16'hffde
`define LPW_VEC_PWT     16'hffdc
`define LPW_VEC_NONE    16'h0000

// stop recovery in crystal reference clock cycles
`define LPW_REC_CNT_W   12
`define LPW_REC_LONG    4096
`define LPW_REC_SHORT   32

// keypad pin count
`define LPW_KBD_PINS    8

`endif

//--- hdl/lpw_pkg.sv
// types shared by the wake control block
package lpw_pkg;

	// operating mode, gray coded along run-wait-stop-recover
	typedef enum logic [1:0]
	{
		LPW_RUN     = 2'b00,
		LPW_WAIT    = 2'b01,
		LPW_STOP    = 2'b11,
		LPW_RECOVER = 2'b10
	} lpw_mode_t;

	// qualified wake requests, highest priority first
	typedef struct packed
	{
		logic reset;
		logic brk;
		logic irq;
		logic pll;
		logic t1_ch0;
		logic t1_ch1;
		logic t1_ovf;
		logic t2_ch0;
		logic t2_ovf;
		logic spi_rx;
		logic spi_tx;
		logic ser_err;
		logic ser_rx;
		logic ser_tx;
		logic kbd;
		logic adc;
		logic pwt;
	} lpw_src_t;

	// run and enable levels handed to the peripherals
	typedef struct packed
	{
		logic ser_run;
		logic spi_run;
		logic tim_run;
		logic pwt_run;
		logic pwt_access;
		logic sdm_active;
		logic irq_active;
		logic kbd_active;
		logic osc_run;
	} lpw_periph_t;

endpackage : lpw_pkg

//--- hdl/lpw_vector_sel.sv
// priority pick of the wake vector among qualified requests
`timescale 1ns/100ps
`include "lpw_regs.svh"

module lpw_vector_sel
	import lpw_pkg::*;
(
	input  wire lpw_src_t    src,
	output logic [15:0]      vector,
	output logic             any,
	output logic             is_reset
);

	////////////////////////////////////////////////////////////////////////
	// fixed priority, higher vector address wins
	function automatic logic [15:0] lpw_pick_vector(input lpw_src_t s);
		logic [15:0] v;
		v = `LPW_VEC_NONE;
		if (s.reset)        v = `LPW_VEC_RESET;
		else if (s.brk)     v = `LPW_VEC_BRK;
		else if (s.irq)     v = `LPW_VEC_IRQ;
		else if (s.pll)     v = `LPW_VEC_PLL;
		else if (s.t1_ch0)  v = `LPW_VEC_T1_CH0;
		else if (s.t1_ch1)  v = `LPW_VEC_T1_CH1;
		else if (s.t1_ovf)  v = `LPW_VEC_T1_OVF;
		else if (s.t2_ch0)  v = `LPW_VEC_T2_CH0;
		else if (s.t2_ovf)  v = `LPW_VEC_T2_OVF;
		else if (s.spi_rx)  v = `LPW_VEC_SPI_RX;
		else if (s.spi_tx)  v = `LPW_VEC_SPI_TX;
		else if (s.ser_err) v = `LPW_VEC_SER_ERR;
		else if (s.ser_rx)  v = `LPW_VEC_SER_RX;
		else if (s.ser_tx)  v = `LPW_VEC_SER_TX;
		else if (s.kbd)     v = `LPW_VEC_KBD;
		else if (s.adc)     v = `LPW_VEC_ADC;
		else if (s.pwt)     v = `LPW_VEC_PWT;
		return v;
	endfunction : lpw_pick_vector

	////////////////////////////////////////////////////////////////////////
	// one wake signal, reset ahead of interrupts
	always_comb
	begin
		vector   = lpw_pick_vector(src);
		any      = |src;
		is_reset = src.reset;
	end

endmodule : lpw_vector_sel

//--- hdl/lpw_recovery_counter.sv
// stop recovery counter clocked by crystal reference edges
`timescale 1ns/100ps
`include "lpw_regs.svh"

module lpw_recovery_counter
	import lpw_pkg::*;
#(
	parameter int CNT_W     = `LPW_REC_CNT_W,
	parameter int REC_LONG  = `LPW_REC_LONG,
	parameter int REC_SHORT = `LPW_REC_SHORT
)
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start,
	input  wire logic short_sel,
	input  wire logic xclk_edge,
	output logic      busy,
	output logic      done
);

	// refuse counts the counter cannot reach
	if (REC_LONG > (2 ** CNT_W) || REC_SHORT < 1 || REC_SHORT > REC_LONG)
	begin : g_bad_cfg
		$error("lpw_recovery_counter: recovery counts do not fit the counter");
	end

	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] last;
		logic             busy;
		logic             done;
	} lpw_rec_st_t;

	lpw_rec_st_t st;
	lpw_rec_st_t next_st;

	////////////////////////////////////////////////////////////////////////
	// count reference edges until the selected length is reached
	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (start)
		begin
			next_st.cnt  = '0;
			next_st.busy = 1'b1;
			next_st.last = short_sel ? CNT_W'(REC_SHORT - 1) : CNT_W'(REC_LONG - 1);
		end
		else if (st.busy && xclk_edge)
		begin
			if (st.cnt == st.last)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			else
			begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign busy = st.busy;
	assign done = st.done;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_REC_TERM:
	assert property (@(posedge clk) disable iff (!resetn)
		st.done |-> $past(st.cnt) == $past(st.last) && $past(xclk_edge))
	else $error("recovery ended before the full count");

	AST_REC_SHORT_LEN:
	assert property (@(posedge clk) disable iff (!resetn)
		(start && short_sel) |=> st.busy && st.last == CNT_W'(REC_SHORT - 1))
	else $error("short recovery length not selected");

endmodule : lpw_recovery_counter

//--- verification/lpw_far_side.sv
// far side model: crystal reference and interrupt pins
`timescale 1ns/100ps
module lpw_far_side
(
	input  wire logic       clk,
	input  wire logic       irq_fire,
	input  wire logic       kbd_fire,
	output logic            crystal_ref_clock = 1'b0,
	output logic            irq_pin_n = 1'b1,
	output logic [7:0]      kbd_pin_n = 8'hff
);
	logic [1:0] div = 2'h0;

	////////////////////////////////////////////////////////////////
	// free running crystal, one reference cycle every four clocks
	always @(posedge clk)
	begin
		div <= div + 2'h1;
		crystal_ref_clock <= div[1];
	end

	////////////////////////////////////////////////////////////////
	// pins idle high on their pull-ups; a request pulls one low
	always @(posedge clk)
	begin
		irq_pin_n <= !irq_fire;
		kbd_pin_n <= kbd_fire ? 8'hdf : 8'hff;
	end
endmodule : lpw_far_side

//--- verification/low_power_wake_control_tb_top.sv
// self-checking bench for the wake control block
`timescale 1ns/100ps
module low_power_wake_control_tb_top
	import lpw_pkg::*;
;
	logic        clk;
	logic        resetn = 1'b0, wait_req = 1'b0, stop_req = 1'b0, osc = 1'b0, shrt = 1'b0;
	logic        im = 1'b0, km = 1'b0, rst_n = 1'b1, sdm_en = 1'b0, sdm_re = 1'b0, sdm_tr = 1'b0;
	logic        irq_fire = 1'b0, kbd_fire = 1'b0;
	logic [14:0] sv = 15'h0;
	logic        xclk, irq_n, cpu_en, bus_en, abort, wp, wbr;
	logic [7:0]  kbd_n;
	logic [15:0] vec;
	lpw_mode_t   mode;
	lpw_periph_t per;
	int          errors = 0, samples_checked = 0, n, aborts = 0;
	logic [15:0] vt [15] = '{16'hfffe, 16'hffdc, 16'hffde, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffe8,
		16'hffea, 16'hffec, 16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffc};
	logic [14:0] pv [3] = '{15'h6400, 15'h1c00, 15'h4001};
	logic [15:0] pe [3] = '{16'hfffc, 16'hfff6, 16'hfffe};

	////////////////////////////////////////////////////////////////
	// clock, far side and design
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	lpw_far_side far (.clk(clk), .irq_fire(irq_fire), .kbd_fire(kbd_fire), .crystal_ref_clock(xclk),
		.irq_pin_n(irq_n), .kbd_pin_n(kbd_n));

	lpw_wake_ctrl #(.REC_LONG(64), .REC_SHORT(4)) dut (.clk(clk), .resetn(resetn), .wait_req(wait_req),
		.stop_req(stop_req), .crystal_ref_clock(xclk), .osc_run_in_stop(osc), .short_recovery_select(shrt),
		.irq_wake_mask(im), .kbd_wake_mask(km), .irq_pin_n(irq_n), .kbd_pin_n(kbd_n), .rst_pin_n(rst_n),
		.wdt_timeout(sv[0]), .sdm_enable(sdm_en), .sdm_reset_enable(sdm_re), .sdm_trip(sdm_tr),
		.break_irq(sv[14]), .pll_irq(sv[13]), .timer_one_irq(sv[12:10]), .timer_two_irq(sv[9:8]),
		.spi_irq(sv[7:6]), .ser_irq(sv[5:3]), .adc_irq(sv[2]), .pwt_rollover(sv[1]), .mode(mode),
		.cpu_clk_en(cpu_en), .bus_clk_en(bus_en), .periph(per), .spi_abort(abort), .wake_pulse(wp),
		.wake_vector(vec), .wake_by_reset(wbr));

	// count spi abort pulses
	always @(posedge clk)
		if (abort === 1'b1)
			aborts++;

	////////////////////////////////////////////////////////////////
	// access tasks
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	task enter(input logic stp);
		@(posedge clk);
		stop_req <= stp;
		wait_req <= !stp;
		@(posedge clk);
		stop_req <= 1'b0;
		wait_req <= 1'b0;
		@(posedge clk);
		#1;
	endtask : enter

	task wake(output int k);
		k = 0;
		while (wp !== 1'b1 && k < 400)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({15'h0, wp}, 16'h1, "wake pulse");
	endtask : wake

	task fire(input int k);
		@(posedge clk);
		if (k == 1)
			kbd_fire <= 1'b1;
		else
			irq_fire <= 1'b1;
		@(posedge clk);
		irq_fire <= 1'b0;
		kbd_fire <= 1'b0;
	endtask : fire

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk(vec, 16'hfffe, "reset vector");
		chk({15'h0, wbr}, 16'h1, "reset flag");
		$display("test reset done");
		for (int i = 0; i < 15; i++)
		begin
			enter(1'b0);
			chk({9'h0, cpu_en, bus_en, per.pwt_access, per.ser_run, per.spi_run, per.tim_run, per.pwt_run},
				16'h2f, "wait levels");
			@(posedge clk) sv <= 15'h1 << i;
			wake(n);
			chk(vec, vt[i], "wait vector");
			chk({15'h0, wbr}, (i == 0) ? 16'h1 : 16'h0, "wait reset flag");
			@(posedge clk) sv <= 15'h0;
		end
		$display("test wait sources done");
		for (int i = 0; i < 3; i++)
		begin
			enter(1'b0);
			@(posedge clk) sv <= pv[i];
			wake(n);
			chk(vec, pe[i], "priority");
			@(posedge clk) sv <= 15'h0;
		end
		$display("test priority done");
		for (int s = 0; s < 2; s++)
			for (int k = 0; k < 2; k++)
			begin
				@(posedge clk);
				im <= 1'b1;
				km <= 1'b1;
				shrt <= 1'b1;
				enter(s[0]);
				fire(k);
				repeat (6) @(posedge clk);
				#1;
				chk({14'h0, mode}, s ? 16'h3 : 16'h1, "masked pin");
				@(posedge clk);
				im <= 1'b0;
				km <= 1'b0;
				fire(k);
				wake(n);
				chk(vec, k ? 16'hffde : 16'hfffa, "pin vector");
				if (s == 1)
					chk({15'h0, n >= 14 && n <= 30}, 16'h1, "short recovery");
			end
		$display("test pins done");
		@(posedge clk);
		sv <= 15'h2003;
		enter(1'b1);
		repeat (8) @(posedge clk);
		#1;
		chk({11'h0, mode, per.pwt_run, per.osc_run, per.ser_run}, 16'h18, "stop idle");
		chk({10'h0, per.spi_run, per.tim_run, per.irq_active, per.kbd_active, cpu_en, bus_en},
			16'hc, "stop halts");
		@(posedge clk);
		sv <= 15'h0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wake(n);
		chk({vec[14:0], wbr}, 16'hfffd, "reset pin wake");
		chk(aborts[15:0], 16'h1, "spi abort");
		@(posedge clk);
		sdm_en <= 1'b1;
		sdm_re <= 1'b1;
		enter(1'b1);
		chk({15'h0, per.sdm_active}, 16'h1, "monitor active");
		@(posedge clk) sdm_tr <= 1'b1;
		wake(n);
		@(posedge clk) sdm_tr <= 1'b0;
		chk(vec, 16'hfffe, "monitor wake");
		@(posedge clk);
		osc <= 1'b1;
		shrt <= 1'b0;
		enter(1'b1);
		chk({14'h0, per.pwt_run, per.osc_run}, 16'h3, "wake timer in stop");
		@(posedge clk) sv <= 15'h2;
		wake(n);
		@(posedge clk) sv <= 15'h0;
		chk(vec, 16'hffdc, "rollover wake");
		chk({15'h0, n >= 250 && n <= 275}, 16'h1, "full recovery");
		chk(aborts[15:0], 16'h2, "no abort on interrupt");
		$display("test stop done");
		complete_run();
	end

	// hang guard, well beyond the longest sequence
	initial
	begin
		#400000;
		errors++;
		complete_run();
	end
endmodule : low_power_wake_control_tb_top
